// ### pkg/dfrc_cfg.svh
/*
 constants for the frequency reference and run control block: register
 offsets, function codes, reset values and timing counts.
 assumes a 25 MHz control clock and a 32-bit classic wishbone slave.
*/
// Contract
// RULE1 - mode digit x zero: stored values act as jump frequencies
// RULE2 - mode digit x one or two: stored values act as offsets
// RULE3 - digit y 5 gives -,+,-; 6 gives +,-,-; 7 to 9 all negative
// RULE4 - digit y 0..4: none, -1, -2, -1-2, -3 negative
// RULE5 - x zero or one: 0.01 Hz units; x two: 0.01 percent of max freq
// RULE6 - any change of mode selection clears all three stored values
// RULE7 - configurer assigns input codes 30, 31, 33 to offset inputs
// RULE8 - final offset is signed sum of offsets whose inputs are on
// RULE9 - monitor shows offset; none at x zero; clamped to unit range
// RULE10 - code 14 searches from max frequency, 15 from set frequency
// RULE11 - sequencer asserts run with or after search, never before
// RULE12 - run active before search command: search ignored
// RULE13 - search decel uses configured time, or 2.0 s when zero
// RULE14 - search starts only when current at or above search level
// RULE15 - startup dc braking for set time in 0.1 s, current in 1%
// RULE16 - brake time zero: skip braking, accelerate from min freq
// RULE17 - brake current zero: baseblock for brake time, then accelerate
// RULE18 - code 16 hold keeps output frequency constant while ramping
// RULE19 - stop while holding releases hold and coasts to stop
// RULE20 - run with hold together: no run unless lower limit >= min freq
// RULE21 - monitor select 0..8 routes freq,cur,dcv,trq,pwr,vref,fref,pid,com
// RULE22 - monitor select honoured only when output type is zero
// RULE23 - monitor scaled by gain; 100 percent gives about 10 V at gain 1
`ifndef DFRC_CFG_SVH
`define DFRC_CFG_SVH
`define DFRC_A_MODE 8'h00
`define DFRC_A_OFS1 8'h04
`define DFRC_A_OFS2 8'h08
`define DFRC_A_OFS3 8'h0c
`define DFRC_A_MFSEL 8'h10
`define DFRC_A_SRCH 8'h14
`define DFRC_A_BRAKE 8'h18
`define DFRC_A_LIMITS 8'h1c
`define DFRC_A_MAXF 8'h20
`define DFRC_A_AMON 8'h24
`define DFRC_A_COMV 8'h28
`define DFRC_A_OFSMON 8'h2c
`define DFRC_A_STATUS 8'h30
`define DFRC_A_FREQ 8'h34
`define DFRC_MF_SRCH_MAX 8'h0e
`define DFRC_MF_SRCH_SET 8'h0f
`define DFRC_MF_HOLD 8'h10
`define DFRC_MF_OFS1 8'h1e
`define DFRC_MF_OFS2 8'h1f
`define DFRC_MF_OFS3 8'h21
`define DFRC_HZ_LIMIT 32'sd40000
`define DFRC_PCT_LIMIT 32'sd10000
`define DFRC_GAIN_UNITY 16'h0064
`define DFRC_FULL_SCALE 16'h03e8
`define DFRC_TICK_NS 100_000_000
`define DFRC_CLK_NS 40
`define DFRC_TICK_CYC (`DFRC_TICK_NS / `DFRC_CLK_NS)
`define DFRC_SRCH_DEF_TENTHS 16'h0014
`define DFRC_RAMP_STEP 32'sd1
`endif

// ### pkg/dfrc_pkg.sv
/*
 types for the frequency reference and run control block.
 assumes dfrc_cfg.svh for numeric constants.
*/
package dfrc_pkg;
	typedef enum logic [2:0] {
		ST_STOP, ST_BRAKE, ST_SEARCH, ST_RUN, ST_COAST
	} dfrc_state_t;
	typedef enum logic [3:0] {
		MON_FREQ, MON_CUR, MON_DCV, MON_TRQ, MON_PWR,
		MON_VREF, MON_FREF, MON_PID, MON_COM
	} dfrc_mon_t;
endpackage

// ### rtl/dfrc_core.sv
/*
 frequency offset, speed search, startup braking, ramp hold and analog
 monitor routing for a motor inverter, with a classic wishbone slave.
 assumes run and multi-function inputs come from pins on another domain; measurement
 inputs are on this clock. long tick count is a parameter.
*/
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "dfrc_cfg.svh"
module dfrc_core #(
	parameter int TICK_CYC = `DFRC_TICK_CYC
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [6:0] i_mf_inputs,
	input wire logic i_forward_run_cmd,
	input wire logic i_reverse_run_cmd,
	input wire logic [15:0] i_out_current,
	input wire logic [15:0] i_dc_bus_volt,
	input wire logic [15:0] i_torque,
	input wire logic [15:0] i_out_power,
	input wire logic [15:0] i_volt_ref,
	input wire logic [15:0] i_freq_ref,
	input wire logic [15:0] i_pid_fb,
	output logic [15:0] o_out_freq,
	output logic signed [31:0] o_final_offset,
	output logic o_offset_is_jump,
	output logic o_dc_brake,
	output logic [7:0] o_dc_brake_level,
	output logic o_baseblock,
	output logic o_searching,
	output logic [15:0] o_analog_monitor_terminals
);
	logic [7:0] offset_mode_select_ff;
	logic [15:0] jump_or_offset_freq_ff [3];
	logic [7:0] multifunction_input_select_ff [7];
	logic [15:0] search_decel_time_ff, search_current_level_ff;
	logic [7:0] start_brake_time_ff, start_brake_current_ff;
	logic [15:0] ref_lower_limit_ff, min_output_freq_ff, max_output_freq_ff;
	logic [15:0] set_freq_ff, com_value_ff, analog_output_gain_ff;
	logic [3:0] analog_monitor_select_ff;
	logic monitor_output_type_ff;
	logic [8:0] pin_s1_ff, pin_s2_ff;
	logic run_prev_ff, srch_prev_ff, srch_armed_ff;
	dfrc_pkg::dfrc_state_t state_ff;
	logic [31:0] tick_cnt_ff;
	logic [15:0] tenths_ff;
	logic signed [31:0] ofs_mon_ff;
	logic [3:0] dig_x, dig_y;
	logic [2:0] neg;
	logic [2:0] ofs_in;
	logic srch_cmd, srch_max, hold_cmd, run_cmd;
	logic wr, tick;
	logic signed [31:0] sum, lim;
	logic [31:0] mon_prod;
	logic [15:0] mon_sel, srch_tenths, srch_step;

	// true when any input with the given function code is on
	function automatic logic mf_on(input logic [7:0] code,
		input logic [6:0] pins, input logic [7:0] sel [7]);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (sel[i] == code && pins[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic [31:0] wmask(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
	assign dig_x = 4'(offset_mode_select_ff[7:4]);
	assign dig_y = 4'(offset_mode_select_ff[3:0]);
	assign run_cmd = pin_s2_ff[7] || pin_s2_ff[8];
	assign ofs_in[0] = mf_on(`DFRC_MF_OFS1, pin_s2_ff[6:0],
		multifunction_input_select_ff); // RULE7
	assign ofs_in[1] = mf_on(`DFRC_MF_OFS2, pin_s2_ff[6:0],
		multifunction_input_select_ff);
	assign ofs_in[2] = mf_on(`DFRC_MF_OFS3, pin_s2_ff[6:0],
		multifunction_input_select_ff);
	assign srch_max = mf_on(`DFRC_MF_SRCH_MAX, pin_s2_ff[6:0],
		multifunction_input_select_ff); // RULE10
	assign srch_cmd = srch_max || mf_on(`DFRC_MF_SRCH_SET,
		pin_s2_ff[6:0], multifunction_input_select_ff);
	assign hold_cmd = mf_on(`DFRC_MF_HOLD, pin_s2_ff[6:0],
		multifunction_input_select_ff); // RULE18
	assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));
	// zero search time falls back to the fixed default
	assign srch_tenths = (search_decel_time_ff == 16'h0000) ?
		`DFRC_SRCH_DEF_TENTHS : search_decel_time_ff; // RULE13
	// floor of one count so a small max still decelerates
	assign srch_step = (max_output_freq_ff < srch_tenths) ? 16'h0001 :
		max_output_freq_ff / srch_tenths;

	always_comb begin
		unique case (dig_y) // RULE3 RULE4
		4'h0: neg = 3'b000;
		4'h1: neg = 3'b001;
		4'h2: neg = 3'b010;
		4'h3: neg = 3'b011;
		4'h4: neg = 3'b100;
		4'h5: neg = 3'b101;
		4'h6: neg = 3'b110;
		default: neg = 3'b111;
		endcase
	end

	always_comb begin
		sum = 32'sd0;
		for (int k = 0; k < 3; k++) begin
			if (ofs_in[k]) begin // RULE8
				sum = neg[k] ? sum - $signed({16'h0000,
					jump_or_offset_freq_ff[k]}) :
					sum + $signed({16'h0000, jump_or_offset_freq_ff[k]});
			end
		end
		// units follow the mode digit: hz hundredths or percent hundredths
		lim = (dig_x == 4'h2) ? `DFRC_PCT_LIMIT : `DFRC_HZ_LIMIT; // RULE5
		if (sum > lim) begin // RULE9
			sum = lim;
		end else if (sum < -lim) begin
			sum = -lim;
		end
		if (dig_x == 4'h0) begin // RULE1
			sum = 32'sd0;
		end
	end

	always_comb begin
		unique case (analog_monitor_select_ff) // RULE21
		4'(dfrc_pkg::MON_FREQ): mon_sel = o_out_freq;
		4'(dfrc_pkg::MON_CUR): mon_sel = i_out_current;
		4'(dfrc_pkg::MON_DCV): mon_sel = i_dc_bus_volt;
		4'(dfrc_pkg::MON_TRQ): mon_sel = i_torque;
		4'(dfrc_pkg::MON_PWR): mon_sel = i_out_power;
		4'(dfrc_pkg::MON_VREF): mon_sel = i_volt_ref;
		4'(dfrc_pkg::MON_FREF): mon_sel = i_freq_ref;
		4'(dfrc_pkg::MON_PID): mon_sel = i_pid_fb;
		default: mon_sel = com_value_ff;
		endcase
		// selected monitor value times gain/unity, gain held in hundredths
		mon_prod = 32'(mon_sel) * 32'(analog_output_gain_ff) /
			32'(`DFRC_GAIN_UNITY); // RULE23
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_ff <= 9'h000;
			pin_s2_ff <= 9'h000;
		end else begin
			pin_s1_ff <= {i_reverse_run_cmd, i_forward_run_cmd, i_mf_inputs};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			offset_mode_select_ff <= 8'h00;
			jump_or_offset_freq_ff <= '{16'h0000, 16'h0000, 16'h0000};
		end else if (wr && i_wb_adr == `DFRC_A_MODE) begin
			offset_mode_select_ff <= 8'(wmask(32'(offset_mode_select_ff),
				i_wb_dat, i_wb_sel));
			if (8'(wmask(32'(offset_mode_select_ff), i_wb_dat, i_wb_sel))
				!= offset_mode_select_ff) begin
				jump_or_offset_freq_ff <= '{16'h0000, 16'h0000,
					16'h0000}; // RULE6
			end
		end else if (wr) begin
			for (int k = 0; k < 3; k++) begin
				if (i_wb_adr == 8'(`DFRC_A_OFS1 + 4 * k)) begin // RULE2
					jump_or_offset_freq_ff[k] <= 16'(wmask(
						32'(jump_or_offset_freq_ff[k]), i_wb_dat, i_wb_sel));
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 7; i++) begin
				multifunction_input_select_ff[i] <= 8'h00;
			end
			search_decel_time_ff <= 16'h0000;
			search_current_level_ff <= 16'h0000;
			start_brake_time_ff <= 8'h00;
			start_brake_current_ff <= 8'h00;
			ref_lower_limit_ff <= 16'h0000;
			min_output_freq_ff <= 16'h0000;
			max_output_freq_ff <= 16'h0000;
			set_freq_ff <= 16'h0000;
			analog_monitor_select_ff <= 4'h0;
			monitor_output_type_ff <= 1'b0;
			analog_output_gain_ff <= `DFRC_GAIN_UNITY;
			com_value_ff <= 16'h0000;
		end else if (wr) begin
			unique case (i_wb_adr)
			`DFRC_A_MFSEL: begin
				for (int i = 0; i < 4; i++) begin
					if (i_wb_sel[i]) begin
						multifunction_input_select_ff[i] <= i_wb_dat[8*i +: 8];
					end
				end
			end
			`DFRC_A_SRCH: begin
				search_decel_time_ff <= i_wb_dat[15:0];
				search_current_level_ff <= i_wb_dat[31:16];
			end
			`DFRC_A_BRAKE: begin
				start_brake_time_ff <= i_wb_dat[7:0];
				start_brake_current_ff <= i_wb_dat[15:8];
				multifunction_input_select_ff[4] <= i_wb_dat[23:16];
				multifunction_input_select_ff[5] <= i_wb_dat[31:24];
			end
			`DFRC_A_LIMITS: begin
				ref_lower_limit_ff <= i_wb_dat[15:0];
				min_output_freq_ff <= i_wb_dat[31:16];
			end
			`DFRC_A_MAXF: begin
				max_output_freq_ff <= i_wb_dat[15:0];
				set_freq_ff <= i_wb_dat[31:16];
			end
			`DFRC_A_AMON: begin
				analog_monitor_select_ff <= i_wb_dat[3:0];
				monitor_output_type_ff <= i_wb_dat[4];
				analog_output_gain_ff <= i_wb_dat[31:16];
			end
			`DFRC_A_COMV: com_value_ff <= i_wb_dat[15:0];
			default: ;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
			unique case (i_wb_adr)
			`DFRC_A_MODE: o_wb_dat <= 32'(offset_mode_select_ff);
			`DFRC_A_OFS1: o_wb_dat <= 32'(jump_or_offset_freq_ff[0]);
			`DFRC_A_OFS2: o_wb_dat <= 32'(jump_or_offset_freq_ff[1]);
			`DFRC_A_OFS3: o_wb_dat <= 32'(jump_or_offset_freq_ff[2]);
			`DFRC_A_MFSEL: o_wb_dat <= {multifunction_input_select_ff[3],
				multifunction_input_select_ff[2],
				multifunction_input_select_ff[1],
				multifunction_input_select_ff[0]};
			`DFRC_A_SRCH: o_wb_dat <= {search_current_level_ff,
				search_decel_time_ff};
			`DFRC_A_BRAKE: o_wb_dat <= {multifunction_input_select_ff[5],
				multifunction_input_select_ff[4], start_brake_current_ff,
				start_brake_time_ff};
			`DFRC_A_LIMITS: o_wb_dat <= {min_output_freq_ff,
				ref_lower_limit_ff};
			`DFRC_A_MAXF: o_wb_dat <= {set_freq_ff, max_output_freq_ff};
			`DFRC_A_AMON: o_wb_dat <= {analog_output_gain_ff, 11'h000,
				monitor_output_type_ff, analog_monitor_select_ff};
			`DFRC_A_COMV: o_wb_dat <= 32'(com_value_ff);
			`DFRC_A_OFSMON: o_wb_dat <= ofs_mon_ff; // RULE9
			`DFRC_A_STATUS: o_wb_dat <= {24'h000000, o_searching,
				o_baseblock, o_dc_brake, 2'b00, 3'(state_ff)};
			`DFRC_A_FREQ: o_wb_dat <= 32'(o_out_freq);
			default: o_wb_dat <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_final_offset <= 32'sd0;
			ofs_mon_ff <= 32'sd0;
			o_offset_is_jump <= 1'b1;
		end else begin
			o_final_offset <= sum;
			ofs_mon_ff <= sum;
			o_offset_is_jump <= (dig_x == 4'h0); // RULE1
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_analog_monitor_terminals <= 16'h0000;
		end else if (!monitor_output_type_ff) begin // RULE22
			o_analog_monitor_terminals <= mon_prod[15:0];
		end else begin
			o_analog_monitor_terminals <= 16'h0000;
		end
	end

	// search arms only on its own rising edge while run is not yet on
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_prev_ff <= 1'b0;
			srch_prev_ff <= 1'b0;
			srch_armed_ff <= 1'b0;
		end else begin
			run_prev_ff <= run_cmd;
			srch_prev_ff <= srch_cmd;
			if (!srch_cmd) begin
				srch_armed_ff <= 1'b0;
			end else if (!srch_prev_ff && !run_prev_ff) begin // RULE11 RULE12
				srch_armed_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else if (tick || state_ff == dfrc_pkg::ST_STOP) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= dfrc_pkg::ST_STOP;
			tenths_ff <= 16'h0000;
			o_out_freq <= 16'h0000;
			o_dc_brake <= 1'b0;
			o_dc_brake_level <= 8'h00;
			o_baseblock <= 1'b1;
			o_searching <= 1'b0;
		end else begin
			unique case (state_ff)
			dfrc_pkg::ST_STOP: begin
				o_out_freq <= 16'h0000;
				o_baseblock <= 1'b1;
				tenths_ff <= 16'h0000;
				if (run_cmd && hold_cmd && !run_prev_ff) begin
					// lower limit run only; otherwise refuse to start
					if (ref_lower_limit_ff >= min_output_freq_ff) begin // RULE20
						o_out_freq <= ref_lower_limit_ff;
						o_baseblock <= 1'b0;
						state_ff <= dfrc_pkg::ST_RUN;
					end
				end else if (run_cmd && srch_cmd &&
					(srch_armed_ff || !run_prev_ff)) begin // RULE12
					o_searching <= 1'b1;
					o_baseblock <= 1'b0;
					o_out_freq <= srch_max ? max_output_freq_ff :
						set_freq_ff; // RULE10
					state_ff <= dfrc_pkg::ST_SEARCH;
				end else if (run_cmd && !hold_cmd) begin
					if (start_brake_time_ff == 8'h00) begin // RULE16
						o_out_freq <= min_output_freq_ff;
						o_baseblock <= 1'b0;
						state_ff <= dfrc_pkg::ST_RUN;
					end else begin
						o_dc_brake <= (start_brake_current_ff != 8'h00);
						o_dc_brake_level <= start_brake_current_ff; // RULE15
						o_baseblock <= (start_brake_current_ff == 8'h00); // RULE17
						state_ff <= dfrc_pkg::ST_BRAKE;
					end
				end
			end
			dfrc_pkg::ST_BRAKE: begin
				if (!run_cmd) begin
					o_dc_brake <= 1'b0;
					o_baseblock <= 1'b1;
					state_ff <= dfrc_pkg::ST_STOP;
				end else if (tick) begin
					tenths_ff <= tenths_ff + 16'h0001;
					if (tenths_ff + 16'h0001 >= 16'(start_brake_time_ff)) begin
						o_dc_brake <= 1'b0;
						o_baseblock <= 1'b0;
						o_out_freq <= min_output_freq_ff; // RULE17
						state_ff <= dfrc_pkg::ST_RUN;
					end
				end
			end
			dfrc_pkg::ST_SEARCH: begin
				if (!run_cmd) begin
					o_searching <= 1'b0;
					state_ff <= dfrc_pkg::ST_COAST;
				end else if (i_out_current < search_current_level_ff) begin
					// current fell below level: speed found, resume run
					o_searching <= 1'b0;
					state_ff <= dfrc_pkg::ST_RUN;
				end else if (tick && o_out_freq != 16'h0000) begin // RULE14
					o_out_freq <= (o_out_freq > srch_step) ?
						o_out_freq - srch_step : 16'h0000; // RULE13
				end
			end
			dfrc_pkg::ST_RUN: begin
				if (!run_cmd) begin
					o_baseblock <= 1'b1;
					state_ff <= hold_cmd ? dfrc_pkg::ST_COAST :
						dfrc_pkg::ST_STOP; // RULE19
				end else if (!hold_cmd && tick) begin // RULE18
					if (o_out_freq < set_freq_ff) begin
						o_out_freq <= o_out_freq + 16'h0001;
					end else if (o_out_freq > set_freq_ff) begin
						o_out_freq <= o_out_freq - 16'h0001;
					end
				end
			end
			dfrc_pkg::ST_COAST: begin
				o_baseblock <= 1'b1;
				o_out_freq <= 16'h0000;
				state_ff <= dfrc_pkg::ST_STOP;
			end
			default: state_ff <= dfrc_pkg::ST_STOP;
			endcase
		end
	end
endmodule

// ### dv/dfrc_core_asserts.sv
/*
 concurrent checks on the ports of dfrc_core.
 assumes binding to dfrc_core with TICK_CYC handed on.
*/
`timescale 1ns/1ps
`include "dfrc_cfg.svh"
module dfrc_core_asserts #(
	parameter int TICK_CYC = 10
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [15:0] o_out_freq,
	input wire logic signed [31:0] o_final_offset,
	input wire logic o_offset_is_jump,
	input wire logic o_dc_brake,
	input wire logic [7:0] o_dc_brake_level,
	input wire logic o_baseblock,
	input wire logic o_searching
);
	// longest brake: 255 tenths plus one tick of phase slack
	localparam int BRAKE_MAX = 256 * TICK_CYC + 4;
	logic [31:0] brake_cnt_ff;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			brake_cnt_ff <= '0;
		else if (o_dc_brake)
			brake_cnt_ff <= brake_cnt_ff + 32'h1;
		else
			brake_cnt_ff <= '0;
	end
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_ack_once;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	a_ack_latency: assert property (s_req |=> s_ack_once)
		else $error("ack not a single pulse one cycle after request");
	a_ack_idle: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
		else $error("ack without request");
	a_unmapped_zero: assert property (o_wb_ack && !i_wb_we &&
		i_wb_adr > 8'h34 |-> o_wb_dat == 32'h0)
		else $error("unmapped read not zero");
	a_jump_no_offset: assert property (
		o_offset_is_jump && $past(o_offset_is_jump) |-> o_final_offset == 0)
		else $error("offset present in jump mode");
	a_offset_range: assert property (
		o_final_offset <= `DFRC_HZ_LIMIT && o_final_offset >= -`DFRC_HZ_LIMIT)
		else $error("offset outside range");
	a_brake_level: assert property (o_dc_brake |-> o_dc_brake_level != 8'h0)
		else $error("dc brake with zero current");
	a_search_start: assert property ($rose(o_searching) |-> o_out_freq != 16'h0)
		else $error("search started from zero");
	a_search_decel: assert property (
		o_searching && $past(o_searching) |-> o_out_freq <= $past(o_out_freq))
		else $error("frequency rose during search");
	a_search_no_brake: assert property (o_searching |-> !o_dc_brake)
		else $error("brake during search");
	a_brake_bound: assert property (brake_cnt_ff <= BRAKE_MAX)
		else $error("dc brake too long");
endmodule

// ### dv/dfrc_seq_model.sv
/*
 run sequencer model driving the multi-function and run pins.
 assumes pin slots: 0..2 offsets, 3 search max, 4 search set, 5 hold.
*/
`timescale 1ns/1ps
module dfrc_seq_model (
	input wire logic i_clock,
	input wire logic [2:0] i_ofs,
	input wire logic i_srch_max,
	input wire logic i_srch_set,
	input wire logic i_hold,
	input wire logic i_run,
	input wire logic i_rev,
	input wire logic i_run_first,
	output logic [6:0] o_mf_inputs = 7'h0,
	output logic o_fwd = 1'b0,
	output logic o_rev = 1'b0
);
	logic srch_ok;
	// a late search is held back unless the bench asks to break order
	always_comb srch_ok = !(o_fwd || o_rev) || i_run_first ||
		o_mf_inputs[3] || o_mf_inputs[4];
	always_ff @(posedge i_clock) begin
		o_mf_inputs <= {1'b0, i_hold, i_srch_set & srch_ok,
			i_srch_max & srch_ok, i_ofs};
		o_fwd <= i_run & !i_rev;
		o_rev <= i_run & i_rev;
	end
endmodule

// ### dv/tb_drive_freq_ref_run_control.sv
/*
 self-checking bench for dfrc_core over wishbone and sequencer pins.
 assumes dfrc_seq_model on the pins and a short tick parameter.
*/
`timescale 1ns/1ps
`include "dfrc_cfg.svh"
module tb_drive_freq_ref_run_control;
	localparam int TICK_CYC = 10;
	logic i_clock = 0, i_arst_n = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0, rd;
	logic [15:0] m [7];
	logic [31:0] o_wb_dat;
	logic o_wb_ack, forward_run_cmd, reverse_run_cmd, o_offset_is_jump, o_dc_brake, o_baseblock;
	logic o_searching;
	logic [6:0] mf;
	logic [15:0] o_out_freq, o_amon;
	logic signed [31:0] o_final_offset, e;
	logic [7:0] o_dc_brake_level;
	logic [2:0] c_ofs = 0, pat, neg;
	logic c_smax = 0, c_sset = 0, c_hold = 0, c_run = 0, c_rev = 0;
	logic c_first = 0;
	logic signed [31:0] vals [3] = '{32'sd100, 32'sd20, 32'sd3};
	int errors = 0, cmp_count = 0, cycles = 0, n;
	dfrc_core #(.TICK_CYC(TICK_CYC)) i_dut (.i_clock(i_clock),
		.i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_mf_inputs(mf), .i_forward_run_cmd(forward_run_cmd),
		.i_reverse_run_cmd(reverse_run_cmd), .i_out_current(m[0]), .i_dc_bus_volt(m[1]),
		.i_torque(m[2]), .i_out_power(m[3]), .i_volt_ref(m[4]),
		.i_freq_ref(m[5]), .i_pid_fb(m[6]), .o_out_freq(o_out_freq),
		.o_final_offset(o_final_offset), .o_offset_is_jump(o_offset_is_jump),
		.o_dc_brake(o_dc_brake), .o_dc_brake_level(o_dc_brake_level),
		.o_baseblock(o_baseblock), .o_searching(o_searching),
		.o_analog_monitor_terminals(o_amon));
	dfrc_seq_model i_seq (.i_clock(i_clock), .i_ofs(c_ofs),
		.i_srch_max(c_smax), .i_srch_set(c_sset), .i_hold(c_hold),
		.i_run(c_run), .i_rev(c_rev), .i_run_first(c_first),
		.o_mf_inputs(mf), .o_fwd(forward_run_cmd), .o_rev(reverse_run_cmd));
	task automatic conclude;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clock);
		end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, string s);
		wb(0, a, 32'h0);
		chk(rd, x, s);
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge i_clock);
	endtask
	function automatic logic flag(input int k);
		case (k)
			0: return o_searching;
			1: return o_dc_brake;
			default: return o_baseblock;
		endcase
	endfunction
	task automatic wait_flag(input int k, input logic v);
		n = 0;
		while (flag(k) !== v && n < 2000) begin
			@(posedge i_clock);
			n++;
		end
	endtask
	task automatic set_brake(input logic [7:0] t, input logic [7:0] c);
		wr(`DFRC_A_BRAKE, {`DFRC_MF_HOLD, `DFRC_MF_SRCH_SET, c, t});
	endtask
	task automatic near_min(input string s);
		chk(32'(o_out_freq >= 16'd30 && o_out_freq <= 16'd31), 32'h1, s);
	endtask
	task automatic stop_coast;
		logic [15:0] f;
		c_hold <= 1;
		tk(6);
		f = o_out_freq;
		tk(3 * TICK_CYC);
		chk(o_out_freq, f, "hold");
		c_run <= 0;
		tk(6);
		chk(o_baseblock, 1, "coast");
		chk(o_out_freq, 0, "coast freq");
		c_hold <= 0;
		tk(6);
	endtask
	task automatic run_search(input logic mx, input logic [15:0] f0,
		input logic [15:0] st);
		c_smax <= mx;
		c_sset <= !mx;
		c_run <= 1;
		tk(6);
		chk(o_searching, 1, "search on");
		chk(o_out_freq, f0, "search start");
		n = 0;
		while (o_out_freq === f0 && n < 100) begin
			@(posedge i_clock);
			n++;
		end
		chk(o_out_freq, f0 - st, "search step");
		m[0] <= 16'd10;
		wait_flag(0, 0);
		chk(32'(n < 20), 32'h1, "search end");
		c_smax <= 0;
		c_sset <= 0;
		m[0] <= 16'd100;
		stop_coast();
	endtask
	initial forever #20 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			conclude();
		end
	end
	initial begin
		for (int i = 0; i < 7; i++)
			m[i] = 16'(20 * (i + 1));
		tk(8);
		i_arst_n <= 1;
		chk(o_offset_is_jump, 1, "rst jump");
		chk(o_baseblock, 1, "rst block");
		wr(`DFRC_A_MFSEL, {`DFRC_MF_SRCH_MAX, `DFRC_MF_OFS3, `DFRC_MF_OFS2,
			`DFRC_MF_OFS1});
		rd_chk(`DFRC_A_MFSEL, 32'h0e211f1e, "mfsel");
		rd_chk(8'hfc, 32'h0, "unmapped");
		wr(`DFRC_A_MAXF, {16'd600, 16'd1000});
		wr(`DFRC_A_COMV, 32'd88);
		wr(`DFRC_A_LIMITS, {16'd30, 16'd10});
		for (int y = 0; y < 10; y++) begin
			wr(`DFRC_A_MODE, {24'h0, 4'h1, 4'(y)});
			for (int i = 0; i < 3; i++)
				rd_chk(8'(`DFRC_A_OFS1 + 4 * i), 32'h0, "clear");
			for (int i = 0; i < 3; i++)
				wr(8'(`DFRC_A_OFS1 + 4 * i), vals[i]);
			pat = 3'(y % 7 + 1);
			neg = (y > 6) ? 3'h7 : 3'(y);
			c_ofs <= pat;
			tk(6);
			e = 0;
			for (int i = 0; i < 3; i++)
				if (pat[i])
					e += neg[i] ? -vals[i] : vals[i];
			chk(o_final_offset, e, "sum");
			rd_chk(`DFRC_A_OFSMON, e, "ofs mon");
		end
		chk(o_offset_is_jump, 0, "offset mode");
		c_ofs <= 3'h3;
		for (int i = 0; i < 3; i++) begin
			wr(`DFRC_A_MODE, (i == 0) ? 32'h10 : (i == 1) ? 32'h20 : 32'h27);
			wr(`DFRC_A_OFS1, (i == 0) ? 32'd30000 : 32'd9000);
			wr(`DFRC_A_OFS2, (i == 0) ? 32'd20000 : 32'd9000);
			tk(6);
			chk(o_final_offset, (i == 0) ? 40000 : (i == 1) ? 10000 : -10000,
				"clamp");
		end
		wr(`DFRC_A_MODE, 32'h0);
		tk(6);
		chk(o_offset_is_jump, 1, "jump");
		chk(o_final_offset, 0, "jump ofs");
		rd_chk(`DFRC_A_OFSMON, 32'h0, "jump mon");
		c_ofs <= 0;
		for (int s = 0; s < 9; s++) begin
			wr(`DFRC_A_AMON, {16'd100, 12'h0, 4'(s)});
			tk(2);
			chk(o_amon, (s == 0) ? 0 : (s == 8) ? 88 : 20 * s, "mon");
		end
		wr(`DFRC_A_AMON, {16'd50, 12'h0, 4'h1});
		tk(2);
		chk(o_amon, 16'd10, "gain");
		wr(`DFRC_A_AMON, {16'd100, 11'h0, 1'b1, 4'h1});
		tk(2);
		chk(o_amon, 16'd0, "type");
		m[0] <= 16'd100;
		set_brake(0, 0);
		wr(`DFRC_A_SRCH, {16'd50, 16'd0});
		run_search(1, 16'd1000, 16'd50);
		wr(`DFRC_A_SRCH, {16'd50, 16'd10});
		run_search(0, 16'd600, 16'd100);
		c_first <= 1;
		c_rev <= 1;
		c_run <= 1;
		tk(6);
		c_smax <= 1;
		tk(6);
		chk(o_searching, 0, "late search");
		c_smax <= 0;
		stop_coast();
		c_first <= 0;
		c_rev <= 0;
		set_brake(3, 40);
		c_run <= 1;
		tk(6);
		chk(o_dc_brake, 1, "brake");
		chk(o_dc_brake_level, 8'd40, "brake lvl");
		wait_flag(1, 0);
		chk(32'(n >= 15 && n <= 42), 32'h1, "brake time");
		stop_coast();
		set_brake(2, 0);
		c_run <= 1;
		tk(6);
		chk(o_baseblock, 1, "bb brake");
		chk(o_dc_brake, 0, "bb no dc");
		wait_flag(2, 0);
		near_min("bb accel");
		stop_coast();
		set_brake(0, 40);
		c_run <= 1;
		tk(6);
		chk(o_dc_brake, 0, "no brake");
		chk(o_baseblock, 0, "no block");
		near_min("min start");
		stop_coast();
		c_hold <= 1;
		c_run <= 1;
		tk(20);
		chk(o_out_freq, 0, "hold run");
		chk(o_baseblock, 1, "hold run bb");
		c_run <= 0;
		tk(6);
		wr(`DFRC_A_LIMITS, {16'd30, 16'd40});
		c_run <= 1;
		tk(20);
		chk(o_out_freq, 16'd40, "lower limit");
		c_run <= 0;
		tk(6);
		chk(o_baseblock, 1, "hold stop");
		c_hold <= 0;
		i_arst_n <= 0;
		tk(2);
		chk(o_offset_is_jump, 1, "re-rst");
		i_arst_n <= 1;
		tk(2);
		conclude();
	end
endmodule
bind dfrc_core dfrc_core_asserts #(.TICK_CYC(TICK_CYC)) i_chk (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_out_freq(o_out_freq),
	.o_final_offset(o_final_offset), .o_offset_is_jump(o_offset_is_jump),
	.o_dc_brake(o_dc_brake), .o_dc_brake_level(o_dc_brake_level),
	.o_baseblock(o_baseblock), .o_searching(o_searching));
